// ### rtl/timebase_map.svh
// Register offsets, reset values and field layout of the time base counters
`ifndef TIMEBASE_MAP_SVH
`define TIMEBASE_MAP_SVH

`define TB_ADDR_W      8
`define TB_OFS_CTRL    8'h00
`define TB_OFS_STEP    8'h04
`define TB_OFS_TC      8'h08
`define TB_OFS_STAT    8'h0C
`define TB_OFS_MASK    8'h10
`define TB_OFS_PR_IN   8'h20
`define TB_OFS_POS_IN  8'h30
`define TB_OFS_PR_RD   8'h40
`define TB_OFS_POS_RD  8'h50
`define TB_PR_BYTES    2
`define TB_POS_BYTES   4
`define TB_PR_W        16
`define TB_POS_W       26
`define TB_CTRL_RST    4'h4
`define TB_INIT_LOW16  16'hFFFF
`define TB_EV_W        2
`define TB_EV_PR       0
`define TB_EV_POS      1

`endif

// ### rtl/timebase_pkg.sv
// Types shared by the time base counter block
`default_nettype none

package timebase_pkg;

	typedef struct packed
	{
		logic rearm_set_n;
		logic rearm_clear_n;
		logic step_mode;
		logic init_n;
	} ctrl_t;

	typedef struct packed
	{
		logic position;
		logic postrec;
	} tc_t;

endpackage

`default_nettype wire

// ### rtl/window_down_counter.sv
// Loadable down-counter with terminal count and inverted readback
`timescale 1ns/100ps
`default_nettype none

module window_down_counter #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire  logic         clk,
	input  wire  logic         rst_n,
	// Control
	input  wire  logic         tick,
	input  wire  logic         load_n,
	input  wire  logic [W-1:0] din,
	input  wire  logic [W-1:0] init_val,
	// Status
	output logic [W-1:0]       count_q,
	output logic [W-1:0]       readback,
	output logic               tc
);

	logic [W-1:0] last_q;

	// Borrow ripples from bit 0 upward through every stage
	function automatic logic [W-1:0] ripple_dec(input logic [W-1:0] v);
		logic         borrow;
		logic [W-1:0] r;
		borrow = 1'b1;
		r      = '0;
		for (int i = 0; i < W; i++)
		begin
			r[i]   = v[i] ^ borrow;
			borrow = borrow & ~v[i];
		end
		return r;
	endfunction

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= {W{1'b1}};
		else if (tick && !load_n)
			count_q <= din;
		else if (tick && count_q != '0)
			count_q <= ripple_dec(count_q);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			last_q <= {W{1'b1}};
		else if (tick && !load_n)
			last_q <= din;
	end

	// Zero holds: no tick branch leaves zero except a load
	assign tc       = (count_q == '0);
	assign readback = tc ? ~last_q : ~count_q;

	// Initial value only documents the width of the loaded pattern
	logic unused_init;
	assign unused_init = ^init_val;

endmodule

`default_nettype wire

// ### rtl/timebase_window_down_counter.sv
// APB-reached post-record and position down-counters with step clocking
// How it works
// - Load low: ticked clock edge copies latches in
// - Set low, clear high drives rearm low
// - Unloaded nonzero counter decrements by one
// - Terminal count high only at zero
// - Readback is ones complement of count
// - At zero, read inverse of last load
// - Loaded zero reads all ones, flag set
// - Post-record counter is sixteen bits wide
// - Step read gives one clock step
// - Init loads all ones into low bits
// - Rearm and complement control counters
// - Terminal count register always readable
`timescale 1ns/100ps
`default_nettype none
`include "timebase_map.svh"

module timebase_window_down_counter
	import timebase_pkg::*;
#(
	parameter int PR_W  = `TB_PR_W,
	parameter int POS_W = `TB_POS_W
) (
	// Clock and reset
	input  wire  logic                  clk,
	input  wire  logic                  rst_n,
	// APB slave
	input  wire  logic                  psel,
	input  wire  logic                  penable,
	input  wire  logic                  pwrite,
	input  wire  logic [`TB_ADDR_W-1:0] paddr,
	input  wire  logic [31:0]           pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Counter status
	output logic                        postrec_load_n,
	output logic                        rearm_h,
	output logic                        window_pace,
	output logic                        irq
);

	logic                  rst_s1_q;
	logic                  rst_s2_q;
	logic                  rst_i_n;
	ctrl_t                 ctrl_q;
	logic                  rearm_n_q;
	logic                  step_q;
	logic                  tick;
	logic [31:0]           pr_in_q;
	logic [31:0]           pos_in_q;
	logic [PR_W-1:0]       pr_cnt;
	logic [PR_W-1:0]       pr_rb;
	logic [POS_W-1:0]      pos_cnt;
	logic [POS_W-1:0]      pos_rb;
	tc_t                   tc;
	tc_t                   tc_prev_q;
	logic [`TB_EV_W-1:0]   stat_q;
	logic [`TB_EV_W-1:0]   mask_q;
	logic [`TB_EV_W-1:0]   ev;
	logic                  pace_q;
	logic                  setup;
	logic                  acc;
	logic                  wr;
	logic                  rd;
	logic                  hit;
	logic [31:0]           rd_d;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_i_n = rst_s2_q;

	// Byte lane of a word selected by index
	function automatic logic [7:0] byte_of(input logic [31:0] v,
	                                       input logic [1:0]  idx);
		return v[{idx, 3'b000} +: 8];
	endfunction

	// True when addr falls in a byte-per-word window of n entries at base
	function automatic logic in_win(input logic [`TB_ADDR_W-1:0] a,
	                                input logic [`TB_ADDR_W-1:0] base,
	                                input int                    n);
		return (a >= base) && (a < base + `TB_ADDR_W'(4 * n))
		       && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [1:0] win_idx(input logic [`TB_ADDR_W-1:0] a,
	                                       input logic [`TB_ADDR_W-1:0] base);
		logic [`TB_ADDR_W-1:0] d;
		d = a - base;
		return d[3:2];
	endfunction

	assign setup = psel && !penable;
	assign acc   = psel && penable;
	assign wr    = acc && pwrite;
	assign rd    = acc && !pwrite;

	assign hit = (paddr == `TB_OFS_CTRL) || (paddr == `TB_OFS_STEP)
	          || (paddr == `TB_OFS_TC) || (paddr == `TB_OFS_STAT)
	          || (paddr == `TB_OFS_MASK)
	          || in_win(paddr, `TB_OFS_PR_IN, `TB_PR_BYTES)
	          || in_win(paddr, `TB_OFS_POS_IN, `TB_POS_BYTES)
	          || in_win(paddr, `TB_OFS_PR_RD, `TB_PR_BYTES)
	          || in_win(paddr, `TB_OFS_POS_RD, `TB_POS_BYTES);

	// Zero-wait slave
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;

	// Control latch
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			ctrl_q <= ctrl_t'(`TB_CTRL_RST);
		else if (wr && paddr == `TB_OFS_CTRL)
			ctrl_q <= ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
	end

	// Rearm flop: set/clear pair, both high or both low hold
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			rearm_n_q <= 1'b0;
		else if (!ctrl_q.rearm_set_n && ctrl_q.rearm_clear_n)
			rearm_n_q <= 1'b0;
		else if (ctrl_q.rearm_set_n && !ctrl_q.rearm_clear_n)
			rearm_n_q <= 1'b1;
	end

	// Rearm low enables loading of both counters
	assign postrec_load_n = rearm_n_q;
	assign rearm_h        = ~rearm_n_q;

	// A read of the step location makes one system clock step
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			step_q <= 1'b0;
		else
			step_q <= rd && paddr == `TB_OFS_STEP;
	end

	// Free run unless step mode; in step mode only steps advance
	assign tick = ctrl_q.step_mode ? step_q : 1'b1;

	// Input latches, written a byte at a time, least significant first
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			pr_in_q <= {16'h0000, `TB_INIT_LOW16};
		else if (wr && in_win(paddr, `TB_OFS_PR_IN, `TB_PR_BYTES))
			pr_in_q[{win_idx(paddr, `TB_OFS_PR_IN), 3'b000} +: 8]
				<= pwdata[7:0];
	end

	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			pos_in_q <= {16'h0000, `TB_INIT_LOW16};
		else if (wr && in_win(paddr, `TB_OFS_POS_IN, `TB_POS_BYTES))
			pos_in_q[{win_idx(paddr, `TB_OFS_POS_IN), 3'b000} +: 8]
				<= pwdata[7:0];
	end

	window_down_counter #(
		.W        (PR_W)
	) u_postrec (
		.clk      (clk),
		.rst_n    (rst_i_n),
		.tick     (tick),
		.load_n   (postrec_load_n),
		.din      (pr_in_q[PR_W-1:0]),
		.init_val (pr_in_q[PR_W-1:0]),
		.count_q  (pr_cnt),
		.readback (pr_rb),
		.tc       (tc.postrec)
	);

	window_down_counter #(
		.W        (POS_W)
	) u_position (
		.clk      (clk),
		.rst_n    (rst_i_n),
		.tick     (tick),
		.load_n   (postrec_load_n),
		.din      (pos_in_q[POS_W-1:0]),
		.init_val (pos_in_q[POS_W-1:0]),
		.count_q  (pos_cnt),
		.readback (pos_rb),
		.tc       (tc.position)
	);

	// Terminal count rising edges are the interrupt events
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			tc_prev_q <= '0;
		else
			tc_prev_q <= tc;
	end

	assign ev[`TB_EV_PR]  = tc.postrec && !tc_prev_q.postrec;
	assign ev[`TB_EV_POS] = tc.position && !tc_prev_q.position;

	// Sticky status, cleared by its read; a new event wins
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			stat_q <= '0;
		else if (rd && paddr == `TB_OFS_STAT)
			stat_q <= ev;
		else
			stat_q <= stat_q | ev;
	end

	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			mask_q <= '0;
		else if (wr && paddr == `TB_OFS_MASK)
			mask_q <= pwdata[`TB_EV_W-1:0];
	end

	assign irq = |(stat_q & mask_q);

	// Window pace: held high during global init, else position count done
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			pace_q <= 1'b1;
		else if (!ctrl_q.init_n)
			pace_q <= 1'b1;
		else
			pace_q <= tc.position;
	end
	assign window_pace = pace_q;

	// Read mux
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (paddr == `TB_OFS_CTRL)
			rd_d[$bits(ctrl_t)-1:0] = ctrl_q;
		else if (paddr == `TB_OFS_TC)
			rd_d[1:0] = tc;
		else if (paddr == `TB_OFS_STAT)
			rd_d[`TB_EV_W-1:0] = stat_q;
		else if (paddr == `TB_OFS_MASK)
			rd_d[`TB_EV_W-1:0] = mask_q;
		else if (in_win(paddr, `TB_OFS_PR_IN, `TB_PR_BYTES))
			rd_d[7:0] = byte_of(pr_in_q, win_idx(paddr, `TB_OFS_PR_IN));
		else if (in_win(paddr, `TB_OFS_POS_IN, `TB_POS_BYTES))
			rd_d[7:0] = byte_of(pos_in_q, win_idx(paddr, `TB_OFS_POS_IN));
		else if (in_win(paddr, `TB_OFS_PR_RD, `TB_PR_BYTES))
			rd_d[7:0] = byte_of({{(32-PR_W){1'b0}}, pr_rb},
			                    win_idx(paddr, `TB_OFS_PR_RD));
		else if (in_win(paddr, `TB_OFS_POS_RD, `TB_POS_BYTES))
			rd_d[7:0] = byte_of({{(32-POS_W){1'b0}}, pos_rb},
			                    win_idx(paddr, `TB_OFS_POS_RD));
	end

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge clk or negedge rst_i_n)
	begin
		if (!rst_i_n)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= rd_d;
	end

	logic unused_cnt;
	assign unused_cnt = ^{pr_cnt, pos_cnt, pwdata[31:8]};

endmodule

`default_nettype wire

// ### sim/tbwdc_props.sv
// Port checker for the time base counter block
`timescale 1ns/100ps
`default_nettype none

module tbwdc_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Counter status
	input wire logic        postrec_load_n,
	input wire logic        rearm_h,
	input wire logic        window_pace,
	input wire logic        irq
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire acc = psel && penable;
	wire rda = acc && !pwrite;
	wire wc = acc && pwrite && paddr == 8'h00;
	wire l_on = wc && pwdata[3:2] == 2'h1;
	wire l_off = wc && pwdata[3:2] == 2'h2;
	rearm_pair_a: assert property (rearm_h == !postrec_load_n)
		else $error("rearm pair disagree");
	load_enable_a: assert property ($fell(postrec_load_n) |->
		$past(l_on) || $past(l_on, 2)) else $error("load enabled alone");
	load_disable_a: assert property ($rose(postrec_load_n) |->
		$past(l_off) || $past(l_off, 2)) else $error("load dropped alone");
	step_zero_a: assert property (rda && paddr == 8'h04 |->
		prdata == 32'h0) else $error("step read not zero");
	tc_width_a: assert property (rda && paddr == 8'h08 |->
		prdata[31:2] == 30'h0) else $error("tc read extra bits");
	pos_top_a: assert property (rda && paddr == 8'h5C |->
		prdata[31:2] == 30'h0) else $error("position top bits set");
	pr_byte_a: assert property (rda && paddr == 8'h44 |->
		prdata[31:8] == 24'h0) else $error("postrec byte too wide");
	pace_init_a: assert property (wc && !pwdata[0] |->
		##[1:2] window_pace) else $error("pace low in init");
	err_phase_a: assert property (pslverr |-> acc && pready)
		else $error("error outside access");
endmodule

`default_nettype wire

// ### sim/cpu_model.sv
// Processor model driving the block's APB port
`timescale 1ns/100ps
`default_nettype none

module cpu_model (
	// Clock
	input  wire logic        clk,
	// APB master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
	end
	// Setup cycle, then access held until pready at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ### sim/timebase_window_down_counter_tb.sv
// Self-checking bench for the time base counter block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) \
	begin fail_count++; $display("CHECK FAILED %s exp %h got %h", \
	nm, ex, sn); end end

module timebase_window_down_counter_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	wire logic   psel, penable, pwrite, pready, pslverr;
	wire logic   [7:0] paddr;
	wire logic   [31:0] pwdata, prdata;
	wire logic   postrec_load_n, rearm_h, window_pace, irq;
	int          fail_count = 0;
	int          total_checks = 0;
	int          n, w;
	logic [31:0] q, p, v, m;
	logic [7:0]  ib, rb;
	logic        e;

	always #20 clk = ~clk;

	timebase_window_down_counter dut_u (.clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.postrec_load_n, .rearm_h, .window_pace, .irq);
	cpu_model cpu_u (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		cpu_u.xfer(1'b1, a, d, q, e);
	endtask
	task rd(input logic [7:0] a);
		cpu_u.xfer(1'b0, a, 32'h0, q, e);
	endtask
	// Byte-wide access, lowest byte at lowest address
	task wrv(input logic [7:0] b, input int k, input logic [31:0] d);
		for (int i = 0; i < k; i++)
			wr(b + 8'(4 * i), {24'h0, d[8 * i +: 8]});
	endtask
	task rdv(input logic [7:0] b, input int k);
		v = 32'h0;
		for (int i = 0; i < k; i++)
		begin
			rd(b + 8'(4 * i));
			v[8 * i +: 8] = q[7:0];
		end
	endtask
	// Counter update lands one edge after the step read
	task step;
		rd(8'h04);
		repeat (2) @(posedge clk);
	endtask
	task settle;
		repeat (2) @(negedge clk);
	endtask

	initial
	begin
		#1_000_000;
		fail_count++;
		close_out;
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		`CHK("pace", 1'b1, window_pace)
		`CHK("load_n", 1'b0, postrec_load_n)
		rd(8'h08);
		`CHK("tc init", 32'h0, q)
		rdv(8'h40, 2);
		`CHK("pr init", 32'h0, v)
		for (int c = 0; c < 2; c++)
		begin
			n = c ? 4 : 2;
			w = c ? 26 : 16;
			m = (32'h1 << w) - 32'h1;
			ib = c ? 8'h30 : 8'h20;
			rb = c ? 8'h50 : 8'h40;
			for (int i = w - 1; i >= 0; i--)
			begin
				p = 32'h1 << i;
				wr(8'h00, 32'h6);
				wrv(ib, n, p);
				step;
				wr(8'h00, 32'hA);
				settle;
				`CHK("rearm", 1'b0, rearm_h)
				`CHK("load off", 1'b1, postrec_load_n)
				rd(8'h08);
				`CHK("tc load", 1'b0, q[c])
				rdv(rb, n);
				`CHK("rb load", ~p & m, v)
				step;
				rd(8'h08);
				`CHK("tc count", i == 0, q[c])
				rdv(rb, n);
				`CHK("rb count", ~(i ? p - 1 : p) & m, v)
			end
			step;
			rd(8'h08);
			`CHK("tc hold", 1'b1, q[c])
			rdv(rb, n);
			`CHK("rb hold", ~32'h1 & m, v)
			wr(8'h00, 32'h6);
			wrv(ib, n, 32'h0);
			step;
			wr(8'h00, 32'hA);
			rd(8'h08);
			`CHK("tc zero", 1'b1, q[c])
			rdv(rb, n);
			`CHK("rb zero", m, v)
			if (c == 0)
			begin
				settle;
				`CHK("irq masked", 1'b0, irq)
				wr(8'h10, 32'h1);
				rd(8'h10);
				`CHK("mask", 32'h1, q)
				settle;
				`CHK("irq set", 1'b1, irq)
				rd(8'h0C);
				`CHK("status", 32'h1, q)
				settle;
				`CHK("irq clear", 1'b0, irq)
				rd(8'h0C);
				`CHK("status clr", 32'h0, q)
			end
		end
		rd(8'hFC);
		`CHK("unmapped", 1'b1, e)
		close_out;
	end
endmodule

bind timebase_window_down_counter tbwdc_props chk_u (.clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.postrec_load_n, .rearm_h, .window_pace, .irq);

`default_nettype wire
